// *** src/pie_ctrl.sv ***
// Prioritized interrupt controller with eight event transfer channels.
// Assumes request inputs on pclk, ext_pin asynchronous, APB master.
// Behaviour
// R1: Offered interrupt appears 7 clocks (jump cache) or 11 clocks after request.
// R2: Each node routes to standard interrupt or to a transfer channel.
// R3: Standard service offers the node's vector so the core branches there.
// R4: A transfer steals one granted bus cycle and never branches.
// R5: Transfer moves byte or word, then bumps source, destination or both.
// R6: Channel counter decrements per transfer unless continuous mode.
// R7: Counter reaching zero leaves request set for a standard interrupt.
// R8: Eight independent transfer channels.
// R9: Each node has request, enable and level in its own control register.
// R10: Sixteen priority levels, four bits wide.
// R11: Only strictly higher level than the core's current level is offered.
// R12: Each node owns a dedicated vector location.
// R13: External inputs detect rising, falling or both edges.
// R14: Software trap number sets the matching node's request.
// R15: Software writing the request flag raises an interrupt.
// R16: Vector offset is four times trap number, node 0 is trap 10H.
// R17: Shared nodes accept requests from either of two sources.
// R18: Vector segment register supplies the table's segment.
// R19: Spacing field sets vector distance, default 4 bytes.
// R20: Nodes without control register are reserved and stay idle.
// R21: Equal levels resolve to the lowest node index.
// R22: Request flag clears when its service is accepted.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "pie_regs.svh"
module pie_ctrl #(
    parameter int                NODES    = 96,
    parameter int                NCH      = 8,
    parameter int                NEXT     = 3,
    parameter int                EXT_NODE = 88,
    parameter logic [NODES-1:0]  HAS_REG  = NODES'(~(96'h3f << 82))
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NODES-1:0]  req_in,
    input  wire logic [NODES-1:0]  alt_in,
    input  wire logic [NEXT-1:0]   ext_pin,
    input  wire logic              trap_valid,
    input  wire logic [6:0]        trap_num,
    input  wire pie_pkg::pie_level_t cpu_level,
    input  wire logic              jump_cache,
    output logic                   int_req,
    output pie_pkg::pie_level_t    int_level,
    output logic      [23:0]       int_vector,
    input  wire logic              int_ack,
    output logic                   bus_req,
    output logic      [23:0]       bus_src,
    output logic      [23:0]       bus_dst,
    output logic                   bus_byte,
    input  wire logic              bus_gnt
);
    import pie_pkg::*;
    localparam int NW = $clog2(NODES);

    // Node control: [3:0] level, 4 enable, 5 request, 6 route, [9:7] channel
    logic [9:0]  ctl      [NODES];
    logic [9:0]  next_ctl [NODES];
    logic [23:0] src [NCH], next_src [NCH];
    logic [23:0] dst [NCH], next_dst [NCH];
    logic [19:0] cc  [NCH], next_cc  [NCH];
    logic [7:0]  vec_seg, next_vec_seg;
    logic [1:0]  vec_spc, next_vec_spc;
    logic [2*NEXT-1:0] edge_cfg, next_edge_cfg;
    pie_state_t  st, next_st;
    logic [NW-1:0] win, next_win, best;
    logic [2:0]  wch, next_wch;
    logic [3:0]  wcnt, next_wcnt, best_l;
    logic [3:0]  next_ilvl;
    logic [23:0] next_ivec, next_bsrc, next_bdst;
    logic        next_bbyte, found, go, use_ch, last, hit, next_err;
    logic [31:0] next_rdata;
    logic [NEXT-1:0] ext_s1, ext_s2, ext_p, ext_ev;
    logic        wr, setup;

    // Node register window at 0x000, four bytes per node
    function automatic logic node_hit(input logic [11:0] a);
        return a[11:9] == 3'h0 && int'(a[8:2]) < NODES;
    endfunction
    // Channel window at 0x200: 16 bytes each, source, destination, control
    function automatic logic ch_hit(input logic [11:0] a);
        return a[11:9] == `PIE_CH_SEL && a[8:7] == 2'h0 && int'(a[6:4]) < NCH && a[3:2] != 2'h3;
    endfunction

    assign wr    = psel & penable & pwrite;
    assign setup = psel & ~penable;
    assign pready = 1'b1;
    assign int_req = (st == ST_OFFER);
    assign bus_req = (st == ST_XFER);

    // Edge events on synchronised external pins
    always_comb begin
        for (int k = 0; k < NEXT; k++) begin
            ext_ev[k] = (edge_cfg[2*k] & ext_s2[k] & ~ext_p[k])
                      | (edge_cfg[2*k+1] & ~ext_s2[k] & ext_p[k]); // R13
        end
    end

    // Arbitration: highest enabled pending level, lowest index on ties
    always_comb begin
        found  = 1'b0;
        best_l = 4'h0;
        best   = '0;
        for (int i = 0; i < NODES; i++) begin
            if (HAS_REG[i] && ctl[i][`PIE_F_IR] && ctl[i][`PIE_F_IE] &&
                (!found || ctl[i][3:0] > best_l)) begin // R10 R21
                found  = 1'b1;
                best_l = ctl[i][3:0];
                best   = NW'(i);
            end
        end
        go     = found && best_l > cpu_level; // R11
        use_ch = ctl[best][`PIE_F_RT] &&
                 (cc[ctl[best][9:7]][`PIE_F_CONT] || cc[ctl[best][9:7]][15:0] != 16'h0); // R2 R7
        last   = !cc[wch][`PIE_F_CONT] && cc[wch][15:0] == 16'h1; // R7
    end

    // Service sequencer
    always_comb begin
        next_st    = st;
        next_win   = win;
        next_wch   = wch;
        next_wcnt  = wcnt;
        next_ilvl  = int_level;
        next_ivec  = int_vector;
        next_bsrc  = bus_src;
        next_bdst  = bus_dst;
        next_bbyte = bus_byte;
        case (st)
            ST_IDLE: begin
                if (go) begin
                    next_win  = best;
                    next_wch  = ctl[best][9:7];
                    next_ilvl = best_l;
                    next_ivec = {vec_seg, 16'({9'h0, 7'(best) + `PIE_TRAP_BASE}
                                 << (`PIE_VEC_SHIFT + 5'(vec_spc)))}; // R3 R12 R16 R18 R19
                    next_bsrc  = src[ctl[best][9:7]];
                    next_bdst  = dst[ctl[best][9:7]];
                    next_bbyte = cc[ctl[best][9:7]][`PIE_F_BYTE];
                    next_wcnt  = (jump_cache ? `PIE_RESP_JC : `PIE_RESP_NOJC) - 4'd2; // R1
                    next_st    = use_ch ? ST_XFER : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!ctl[win][`PIE_F_IR] || !ctl[win][`PIE_F_IE]) begin
                    next_st = ST_IDLE;
                end else if (wcnt == 4'h0) begin
                    next_st = ST_OFFER; // R1
                end else begin
                    next_wcnt = wcnt - 4'd1;
                end
            end
            ST_OFFER: begin
                if (int_ack || !ctl[win][`PIE_F_IR] || !ctl[win][`PIE_F_IE]) begin
                    next_st = ST_IDLE;
                end
            end
            default: begin
                if (bus_gnt) begin
                    next_st = ST_IDLE; // R4
                end
            end
        endcase
    end

    // Node flags: write, then service clear, then hardware set (set wins)
    always_comb begin
        for (int i = 0; i < NODES; i++) begin
            next_ctl[i] = ctl[i];
            if (wr && node_hit(paddr) && int'(paddr[8:2]) == i) begin
                next_ctl[i] = pwdata[9:0]; // R9 R15
            end
            if (NW'(i) == win && ((st == ST_OFFER && int_ack) ||
                (st == ST_XFER && bus_gnt && !last))) begin
                next_ctl[i][`PIE_F_IR] = 1'b0; // R22 R7
            end
            if (req_in[i] || alt_in[i] ||
                (trap_valid && trap_num >= `PIE_TRAP_BASE && int'(trap_num - `PIE_TRAP_BASE) == i)) begin
                next_ctl[i][`PIE_F_IR] = 1'b1; // R14 R17
            end
            // Index kept non-negative for every node so no out-of-range select is formed
            if (i >= EXT_NODE && i < EXT_NODE + NEXT && ext_ev[(i + NODES * NEXT - EXT_NODE) % NEXT]) begin
                next_ctl[i][`PIE_F_IR] = 1'b1; // R13
            end
            if (!HAS_REG[i]) begin
                next_ctl[i] = 10'h0; // R20
            end
        end
    end

    // Channel registers and per-transfer updates
    always_comb begin
        for (int c = 0; c < NCH; c++) begin // R8
            next_src[c] = src[c];
            next_dst[c] = dst[c];
            next_cc[c]  = cc[c];
            if (wr && ch_hit(paddr) && int'(paddr[6:4]) == c) begin
                if (paddr[3:2] == 2'h0) next_src[c] = pwdata[23:0];
                else if (paddr[3:2] == 2'h1) next_dst[c] = pwdata[23:0];
                else next_cc[c] = pwdata[19:0];
            end else if (st == ST_XFER && bus_gnt && 3'(c) == wch) begin
                if (cc[c][`PIE_F_INCS]) begin
                    next_src[c] = src[c] + (cc[c][`PIE_F_BYTE] ? 24'h1 : 24'h2); // R5
                end
                if (cc[c][`PIE_F_INCD]) begin
                    next_dst[c] = dst[c] + (cc[c][`PIE_F_BYTE] ? 24'h1 : 24'h2); // R5
                end
                if (!cc[c][`PIE_F_CONT]) begin
                    next_cc[c][15:0] = cc[c][15:0] - 16'h1; // R6
                end
            end
        end
    end

    // Globals and read data, sampled in the setup phase
    always_comb begin
        next_vec_seg  = vec_seg;
        next_vec_spc  = vec_spc;
        next_edge_cfg = edge_cfg;
        next_rdata    = 32'h0;
        hit           = 1'b1;
        if (node_hit(paddr)) begin
            next_rdata = {22'h0, ctl[paddr[8:2]]};
        end else if (ch_hit(paddr)) begin
            if (paddr[3:2] == 2'h0) next_rdata = {8'h0, src[paddr[6:4]]};
            else if (paddr[3:2] == 2'h1) next_rdata = {8'h0, dst[paddr[6:4]]};
            else next_rdata = {12'h0, cc[paddr[6:4]]};
        end else if (paddr == `PIE_VEC_SEG) begin
            next_rdata = {24'h0, vec_seg};
            if (wr) next_vec_seg = pwdata[7:0]; // R18
        end else if (paddr == `PIE_CPU_CFG) begin
            next_rdata = {30'h0, vec_spc};
            if (wr) next_vec_spc = pwdata[1:0]; // R19
        end else if (paddr == `PIE_STATUS) begin
            next_rdata = {16'h0, 1'b0, found, st, 5'h0, 7'(win)};
        end else if (paddr == `PIE_EDGE) begin
            next_rdata = 32'(edge_cfg);
            if (wr) next_edge_cfg = pwdata[2*NEXT-1:0];
        end else begin
            hit = 1'b0;
        end
        next_err = setup ? !hit : pslverr;
        if (!setup) next_rdata = prdata;
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NODES; i++) ctl[i] <= 10'h0;
            for (int c = 0; c < NCH; c++) begin
                src[c] <= 24'h0;
                dst[c] <= 24'h0;
                cc[c]  <= 20'h0;
            end
            vec_seg <= `PIE_VEC_SEG_RST;
            vec_spc <= `PIE_VEC_SPC_RST;
            edge_cfg <= '0;
            st <= ST_IDLE;
            win <= '0;
            wch <= 3'h0;
            wcnt <= 4'h0;
            int_level <= 4'h0;
            int_vector <= 24'h0;
            bus_src <= 24'h0;
            bus_dst <= 24'h0;
            bus_byte <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            ext_s1 <= '0;
            ext_s2 <= '0;
            ext_p <= '0;
        end else begin
            ctl <= next_ctl;
            src <= next_src;
            dst <= next_dst;
            cc <= next_cc;
            vec_seg <= next_vec_seg;
            vec_spc <= next_vec_spc;
            edge_cfg <= next_edge_cfg;
            st <= next_st;
            win <= next_win;
            wch <= next_wch;
            wcnt <= next_wcnt;
            int_level <= next_ilvl;
            int_vector <= next_ivec;
            bus_src <= next_bsrc;
            bus_dst <= next_bdst;
            bus_byte <= next_bbyte;
            prdata <= next_rdata;
            pslverr <= next_err;
            ext_s1 <= ext_pin;
            ext_s2 <= ext_s1;
            ext_p <= ext_s2;
        end
    end

    // Checks
    logic [15:0] cur_cnt;
    logic [23:0] cur_src;
    logic        apb_wr_q;
    assign cur_cnt = cc[wch][15:0];
    assign cur_src = src[wch];
    assign apb_wr_q = wr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_resp_min: assert property ($rose(int_req) |-> $past(st == ST_WAIT, 6)) // R1
        else $error("interrupt offered too early");
    a_higher_only: assert property (int_req |-> int_level > cpu_level) // R11
        else $error("offered level not above core level");
    a_vec_default: assert property (int_req && vec_spc == 2'h0 |-> // R16
        int_vector[15:0] == {7'h0, 7'(win) + 7'h10, 2'b00})
        else $error("vector offset wrong");
    a_ack_clears: assert property (int_req && int_ack && !req_in[win] && !alt_in[win] && !trap_valid // R22
        && !apb_wr_q |=> !ctl[$past(win)][5])
        else $error("request not cleared on accept");
    a_xfer_one: assert property (bus_req && bus_gnt |=> !bus_req && !int_req) // R4
        else $error("transfer held longer than one cycle");
    a_cnt_dec: assert property (bus_req && bus_gnt && !cc[wch][19] && !apb_wr_q |=> // R6
        cur_cnt == 16'($past(cur_cnt) - 16'h1))
        else $error("counter not decremented");
    a_src_inc: assert property (bus_req && bus_gnt && cc[wch][17] && !apb_wr_q |=> // R5
        cur_src == 24'($past(cur_src) + ($past(bus_byte) ? 24'h1 : 24'h2)))
        else $error("source pointer not advanced");
    a_zero_int: assert property (bus_req && bus_gnt && last |=> ctl[win][5] ##1 !bus_req) // R7
        else $error("terminal transfer lost its request");
    a_trap_set: assert property (trap_valid && trap_num >= 7'h10 && trap_num < 7'h70 |=> // R14
        ctl[7'($past(trap_num) - 7'h10)][5] || !HAS_REG[7'($past(trap_num) - 7'h10)])
        else $error("trap did not set request");
    c_std: cover property (int_req && int_ack);
    c_xfer: cover property (bus_req && bus_gnt);
    c_last: cover property (bus_req && bus_gnt && last);
endmodule

// *** src/pie_regs.svh ***
// Register map, field positions, reset values and timing counts.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH
`define PIE_CH_SEL      3'h1
`define PIE_VEC_SEG     12'h300
`define PIE_CPU_CFG     12'h304
`define PIE_STATUS      12'h308
`define PIE_EDGE        12'h30c
`define PIE_F_IE        4
`define PIE_F_IR        5
`define PIE_F_RT        6
`define PIE_F_BYTE      16
`define PIE_F_INCS      17
`define PIE_F_INCD      18
`define PIE_F_CONT      19
`define PIE_TRAP_BASE   7'h10
`define PIE_VEC_SHIFT   5'd2
`define PIE_VEC_SPC_RST 2'h0
`define PIE_VEC_SEG_RST 8'h00
`define PIE_CLK_NS      40
`define PIE_RESP_JC     4'd7
`define PIE_RESP_NOJC   4'd11
`endif

// *** src/pie_pkg.sv ***
// Types shared by the interrupt and event transfer controller.
// Assumes nothing beyond a SystemVerilog tool.
package pie_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_OFFER = 2'b10,
        ST_XFER  = 2'b11
    } pie_state_t;
    typedef logic [3:0] pie_level_t;
endpackage

// *** test/pie_core_model.sv ***
// Core stand-in: accepts offered interrupts and grants stolen bus cycles.
// Assumes one pclk domain; delay sets how long the core hesitates.
`timescale 1ns/10ps
module pie_core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       int_req,
    input  wire logic       bus_req,
    input  wire logic [3:0] delay,
    output logic            int_ack,
    output logic            bus_gnt
);
    logic [3:0] cnt;
    // One answer pulse per request, after the chosen hesitation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_ack <= 1'b0;
            bus_gnt <= 1'b0;
            cnt     <= 4'h0;
        end else begin
            int_ack <= 1'b0;
            bus_gnt <= 1'b0;
            cnt     <= 4'h0;
            if ((int_req || bus_req) && !int_ack && !bus_gnt) begin
                if (cnt >= delay) begin
                    int_ack <= int_req;
                    bus_gnt <= bus_req && !int_req;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

// *** test/test_prioritized_interrupt_and_event_transfer.sv ***
// Self-checking bench for the interrupt and event transfer controller.
// Assumes pie_ctrl with default parameters and the core model beside it.
`timescale 1ns/10ps
`include "pie_regs.svh"
module test_prioritized_interrupt_and_event_transfer;
    import pie_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        trap_valid, jump_cache, int_req, int_ack, bus_req, bus_gnt, bus_byte;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [95:0] req_in, alt_in;
    logic [2:0]  ext_pin;
    logic [6:0]  trap_num;
    logic [23:0] int_vector, bus_src, bus_dst, s, d;
    logic [7:0]  vseg;
    logic [3:0]  delay, lv;
    pie_level_t  cpu_level, int_level;
    logic [31:0] rq[$];
    logic [27:0] vq[$];
    logic [48:0] tq[$];
    int          num_errors, n_checks, cyc, sp, n, c;

    pie_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_in(req_in), .alt_in(alt_in), .ext_pin(ext_pin), .trap_valid(trap_valid),
        .trap_num(trap_num), .cpu_level(cpu_level), .jump_cache(jump_cache), .int_req(int_req),
        .int_level(int_level), .int_vector(int_vector), .int_ack(int_ack), .bus_req(bus_req),
        .bus_src(bus_src), .bus_dst(bus_dst), .bus_byte(bus_byte), .bus_gnt(bus_gnt));
    pie_core_model u_core (.pclk(pclk), .presetn(presetn), .int_req(int_req), .bus_req(bus_req),
        .delay(delay), .int_ack(int_ack), .bus_gnt(bus_gnt));

    // Expected offer: level, then segment and offset of node k
    function automatic logic [27:0] vec(input int k, input logic [3:0] l);
        return {l, vseg, 16'((k + 16) << (2 + sp))};
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] v);
        n_checks++;
        if (e !== v) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, v);
        end
    endtask
    // APB master: setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dt);
        apb(1'b1, a, dt);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input logic [95:0] r, input logic [95:0] a);
        @(posedge pclk);
        req_in <= r;
        alt_in <= a;
        @(posedge pclk);
        req_in <= '0;
        alt_in <= '0;
    endtask
    // Wait for all noted services, then vary core hesitation
    task automatic settle;
        int k;
        k = 0;
        while ((vq.size() + tq.size()) != 0 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        repeat (20) @(posedge pclk);
        chk("pending", 0, vq.size() + tq.size());
        delay <= 4'($urandom_range(15));
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Monitor: each offer, transfer and read takes the oldest note; pslverr is checked against 1
    always @(posedge pclk) begin
        if (presetn && int_req && int_ack)
            chk("int_vector", vq.size() ? vq.pop_front() : 'x, {int_level, int_vector});
        if (presetn && bus_req && bus_gnt)
            chk("bus", tq.size() ? tq.pop_front() : 'x, {bus_src, bus_dst, bus_byte});
        if (psel && penable && pready && !pwrite) chk("prdata", rq.size() ? rq.pop_front() : 'x, prdata);
        if (psel && penable && pready && paddr == 12'h3fc) chk("pslverr", 1, pslverr);
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, trap_valid, jump_cache} = '0;
        {paddr, pwdata, req_in, alt_in, ext_pin, trap_num, vseg, delay, cpu_level} = '0;
        {num_errors, n_checks, cyc, sp} = '0;
        void'($urandom(32'h20ff));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, layout, reserved and unmapped places
        rd(12'h014, 32'h0);
        rd(`PIE_CPU_CFG, 32'h0);
        wr(12'h014, 32'hffffff9f);
        rd(12'h014, 32'h39f);
        wr(12'h014, 32'h0);
        wr(12'h148, 32'h1f);
        rd(12'h148, 32'h0);
        rd(12'h3fc, 32'h0);
        wr(`PIE_VEC_SEG, 32'h12);
        vseg = 8'h12;
        rd(`PIE_VEC_SEG, 32'h12);
        // Priority order, shared source and ties
        wr(12'h00c, 32'h15);
        wr(12'h01c, 32'h19);
        vq.push_back(vec(7, 4'h9));
        vq.push_back(vec(3, 4'h5));
        pulse(96'h1 << 7, 96'h1 << 3);
        settle();
        wr(12'h050, 32'h16);
        wr(12'h078, 32'h16);
        vq.push_back(vec(20, 4'h6));
        vq.push_back(vec(30, 4'h6));
        pulse((96'h1 << 20) | (96'h1 << 30), '0);
        settle();
        // Software trap under spacings 0 and 1
        wr(12'h060, 32'h12);
        for (n = 0; n < 2; n++) begin
            sp = n;
            wr(`PIE_CPU_CFG, 32'(n));
            vq.push_back(vec(24, 4'h2));
            @(posedge pclk);
            trap_valid <= 1'b1;
            trap_num   <= 7'h28;
            @(posedge pclk);
            trap_valid <= 1'b0;
            settle();
        end
        vq.push_back(vec(40, 4'h5));
        wr(12'h0a0, 32'h35);
        settle();
        // Response time with and without jump cache
        lv = 4'($urandom_range(1, 15));
        wr(12'h024, 32'(5'h10 | lv));
        for (c = 0; c < 2; c++) begin
            jump_cache <= c[0];
            vq.push_back(vec(9, lv));
            pulse(96'h1 << 9, '0);
            n = 0;
            do begin
                @(posedge pclk);
                n++;
                @(negedge pclk);
            end while (int_req !== 1'b1 && n < 40);
            chk("resp_clocks", c ? 7 : 11, n);
            settle();
        end
        // Only strictly higher levels preempt
        @(posedge pclk);
        cpu_level <= 4'h9;
        wr(12'h030, 32'h39);
        n = 0;
        repeat (20) begin
            @(negedge pclk);
            n += (int_req !== 1'b0);
        end
        chk("int_req_low", 0, n);
        vq.push_back(vec(12, 4'h9));
        @(posedge pclk);
        cpu_level <= 4'h8;
        settle();
        cpu_level <= 4'h0;
        // Edge detection modes on an external pin
        wr(12'h160, 32'h13);
        for (n = 1; n < 4; n++) begin
            wr(`PIE_EDGE, 32'(n));
            if (n[0]) vq.push_back(vec(88, 4'h3));
            ext_pin[0] <= 1'b1;
            settle();
            if (n[1]) vq.push_back(vec(88, 4'h3));
            ext_pin[0] <= 1'b0;
            settle();
        end
        // Transfer channel: counted words, then continuous bytes
        c = $urandom_range(7);
        s = 24'($urandom) & 24'hfffff0;
        d = 24'($urandom) & 24'hfffff0;
        wr(12'(512 + 16 * c), 32'(s));
        wr(12'(516 + 16 * c), 32'(d));
        wr(12'(520 + 16 * c), 32'h00060002);
        wr(12'h028, 32'(32'h54 | (c << 7)));
        tq.push_back({s, d, 1'b0});
        pulse(96'h1 << 10, '0);
        settle();
        tq.push_back({s + 24'h2, d + 24'h2, 1'b0});
        vq.push_back(vec(10, 4'h4));
        pulse(96'h1 << 10, '0);
        settle();
        rd(12'(520 + 16 * c), 32'h00060000);
        wr(12'(520 + 16 * c), 32'h000b0005);
        for (n = 0; n < 2; n++) begin
            tq.push_back({24'(s + 4 + n), d + 24'h4, 1'b1});
            pulse(96'h1 << 10, '0);
            settle();
        end
        rd(12'(520 + 16 * c), 32'h000b0005);
        give_verdict();
    end
endmodule
